/* File: adc_channel_trigger_clock_ctrl.v */
// top: two converter modules with their control registers on AXI4-Lite
// assumes trigger inputs are asynchronous pulses of at least two cycles
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "adc_ctrl_consts.vh"
// Function
// - single mode selects one input per code
// - scan converts first n+1 inputs ascending
// - channel select bits 1:0, read/write, reset zero
// - end flag cleared only by writing zero
// - separate control register per module
// - trigger enable bit 7 gates trigger starts
// - clock select bits 6:5 divide 32/16/8/4
// - start bit runs, clears, self-clears at end except in continuous scan
// - mode bit chooses single or scan
// - end flag set at conversion or pass end
// - continuous bit repeats scan passes
module adc_channel_trigger_clock_ctrl (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// axi4-lite write address
	input wire [4:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// axi4-lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read address
	input wire [4:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// axi4-lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// trigger sources
	input wire external_trigger_pin,
	input wire [1:0] timer_unit_trigger,
	// status toward the analog front end
	output reg [7:0] analog_input_sel,
	output reg [1:0] busy,
	output reg irq
);
	reg [7:0] csr_r [0:1];
	reg [7:0] ctl_r [0:1];
	reg [1:0] irq_stat_r;
	reg [1:0] irq_mask_r;
	reg [4:0] awaddr_r;
	reg [31:0] wdata_r;
	reg aw_have_r;
	reg w_have_r;
	reg ext_s1_r, ext_s2_r, ext_s3_r;
	reg [1:0] tmr_s1_r, tmr_s2_r, tmr_s3_r;
	wire [1:0] tick;
	wire [1:0] seq_busy;
	wire [1:0] chan_done;
	wire [1:0] pass_done;
	wire [3:0] chan_w;
	wire do_write;
	wire wr_lane0;

	// one-hot analog input from a module's channel code
	function [3:0] chan_onehot;
		input [1:0] code;
		begin
			chan_onehot = 4'h1 << code;
		end
	endfunction

	// address decode shared by read and write
	function [2:0] reg_index;
		input [4:0] addr;
		begin
			case (addr)
				`OFS_CSR0: reg_index = 3'h0;
				`OFS_CTL0: reg_index = 3'h1;
				`OFS_CSR1: reg_index = 3'h2;
				`OFS_CTL1: reg_index = 3'h3;
				`OFS_IRQ_STAT: reg_index = 3'h4;
				`OFS_IRQ_MASK: reg_index = 3'h5;
				default: reg_index = 3'h7;
			endcase
		end
	endfunction

	assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;
	assign wr_lane0 = s_axi_wstrb[0];

	// trigger pins cross two flops; the third flop only feeds the edge detect
	always @(posedge aclk) begin
		if (!aresetn) begin
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
			ext_s3_r <= 1'b0;
			tmr_s1_r <= 2'h0;
			tmr_s2_r <= 2'h0;
			tmr_s3_r <= 2'h0;
		end else begin
			ext_s1_r <= external_trigger_pin;
			ext_s2_r <= ext_s1_r;
			ext_s3_r <= ext_s2_r;
			tmr_s1_r <= timer_unit_trigger;
			tmr_s2_r <= tmr_s1_r;
			tmr_s3_r <= tmr_s2_r;
		end
	end

	// write channels: take address and data in either order, then respond
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			awaddr_r <= 5'h00;
			wdata_r <= 32'h00000000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_have_r && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready <= !w_have_r && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (reg_index(awaddr_r) == 3'h7) ?
					`RESP_SLVERR : `RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// a held write strobe is only used on the single register write cycle
	reg [3:0] wstrb_r;
	always @(posedge aclk) begin
		if (!aresetn)
			wstrb_r <= 4'h0;
		else if (s_axi_wvalid && s_axi_wready)
			wstrb_r <= s_axi_wstrb;
	end

	// per-module registers, sequencer and divider
	genvar m;
	generate
		for (m = 0; m < 2; m = m + 1) begin : g_mod
			wire wr_csr;
			wire wr_ctl;
			wire trig;
			assign wr_csr = do_write && wstrb_r[0] &&
				reg_index(awaddr_r) == 3'h2 * m;
			assign wr_ctl = do_write && wstrb_r[0] &&
				reg_index(awaddr_r) == 3'h2 * m + 3'h1;
			// timer triggers are per module, the pin feeds both
			assign trig = (ext_s2_r && !ext_s3_r) ||
				(tmr_s2_r[m] && !tmr_s3_r[m]);

			// control/status: end flag set wins over a clearing write
			always @(posedge aclk) begin
				if (!aresetn) begin
					csr_r[m] <= `CSR_RESET;
				end else begin
					if (wr_csr) begin
						csr_r[m][`CSR_MODE_BIT] <= wdata_r[`CSR_MODE_BIT];
						csr_r[m][`CSR_CH_HI:`CSR_CH_LO] <=
							wdata_r[`CSR_CH_HI:`CSR_CH_LO];
					end
					if (pass_done[m])
						csr_r[m][`CSR_END_BIT] <= 1'b1;
					else if (wr_csr && !wdata_r[`CSR_END_BIT])
						csr_r[m][`CSR_END_BIT] <= 1'b0;
				end
			end

			// trigger/clock control with self-clearing start bit
			always @(posedge aclk) begin
				if (!aresetn) begin
					ctl_r[m] <= `CTL_RESET;
				end else begin
					if (wr_ctl) begin
						ctl_r[m][`CTL_TRG_BIT] <= wdata_r[`CTL_TRG_BIT];
						ctl_r[m][`CTL_CKS_HI:`CTL_CKS_LO] <=
							wdata_r[`CTL_CKS_HI:`CTL_CKS_LO];
						ctl_r[m][`CTL_SCAN_BIT] <= wdata_r[`CTL_SCAN_BIT];
						ctl_r[m][`CTL_START_BIT] <= wdata_r[`CTL_START_BIT];
					end
					if (pass_done[m] && !(csr_r[m][`CSR_MODE_BIT] &&
						ctl_r[m][`CTL_SCAN_BIT]))
						ctl_r[m][`CTL_START_BIT] <= 1'b0;
					else if (trig && ctl_r[m][`CTL_TRG_BIT] &&
						!ctl_r[m][`CTL_START_BIT])
						ctl_r[m][`CTL_START_BIT] <= 1'b1;
				end
			end

			clk_div_tick u_div (
				.aclk(aclk),
				.aresetn(aresetn),
				.run(ctl_r[m][`CTL_START_BIT]),
				.cks(ctl_r[m][`CTL_CKS_HI:`CTL_CKS_LO]),
				.tick(tick[m])
			);

			conv_sequencer u_seq (
				.aclk(aclk),
				.aresetn(aresetn),
				.start(ctl_r[m][`CTL_START_BIT]),
				.scan(csr_r[m][`CSR_MODE_BIT]),
				.continuous(ctl_r[m][`CTL_SCAN_BIT]),
				.ch_sel(csr_r[m][`CSR_CH_HI:`CSR_CH_LO]),
				.tick(tick[m]),
				.chan(chan_w[2*m+1:2*m]),
				.chan_done(chan_done[m]),
				.pass_done(pass_done[m]),
				.busy(seq_busy[m])
			);
		end
	endgenerate

	// interrupt status sticky on end of pass; set wins over write-one clear
	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_r <= 2'h0;
			irq_mask_r <= 2'h0;
			irq <= 1'b0;
		end else begin
			if (do_write && wstrb_r[0] && reg_index(awaddr_r) == 3'h5)
				irq_mask_r <= wdata_r[1:0];
			if (do_write && wstrb_r[0] && reg_index(awaddr_r) == 3'h4)
				irq_stat_r <= (irq_stat_r & ~wdata_r[1:0]) | pass_done;
			else
				irq_stat_r <= irq_stat_r | pass_done;
			irq <= |(irq_stat_r & irq_mask_r);
		end
	end

	// front end select: module zero on inputs 0..3, module one on 4..7
	always @(posedge aclk) begin
		if (!aresetn) begin
			analog_input_sel <= 8'h00;
			busy <= 2'h0;
		end else begin
			analog_input_sel[3:0] <= seq_busy[0] ?
				chan_onehot(chan_w[1:0]) : 4'h0;
			analog_input_sel[7:4] <= seq_busy[1] ?
				chan_onehot(chan_w[3:2]) : 4'h0;
			busy <= seq_busy;
		end
	end

	// read channel: one cycle from address to data, held until rready
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `RESP_OKAY;
				case (reg_index(s_axi_araddr))
					3'h0: s_axi_rdata <= {24'h000000, csr_r[0]};
					3'h1: s_axi_rdata <= {24'h000000, ctl_r[0]};
					3'h2: s_axi_rdata <= {24'h000000, csr_r[1]};
					3'h3: s_axi_rdata <= {24'h000000, ctl_r[1]};
					3'h4: s_axi_rdata <= {30'h00000000, irq_stat_r};
					3'h5: s_axi_rdata <= {30'h00000000, irq_mask_r};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= `RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

/* File: adc_ctrl_consts.vh */
// constants for the two-module converter control block
// assumes inclusion by bare name from each design file
`ifndef ADC_CTRL_CONSTS_VH
`define ADC_CTRL_CONSTS_VH
// register byte offsets
`define OFS_CSR0 5'h00
`define OFS_CTL0 5'h04
`define OFS_CSR1 5'h08
`define OFS_CTL1 5'h0C
`define OFS_IRQ_STAT 5'h10
`define OFS_IRQ_MASK 5'h14
// control/status fields
`define CSR_END_BIT 7
`define CSR_MODE_BIT 4
`define CSR_RSV1_BIT 3
`define CSR_CH_HI 1
`define CSR_CH_LO 0
`define CSR_RESET 8'h08
// trigger/clock control fields
`define CTL_TRG_BIT 7
`define CTL_CKS_HI 6
`define CTL_CKS_LO 5
`define CTL_START_BIT 4
`define CTL_SCAN_BIT 3
`define CTL_RSV_MASK 8'h07
`define CTL_RESET 8'h07
// divider codes
`define CKS_DIV32 2'h0
`define CKS_DIV16 2'h1
`define CKS_DIV8 2'h2
`define CKS_DIV4 2'h3
// conversion length in conversion clock ticks
`define CONV_TICKS 4'hA
// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* File: clk_div_tick.v */
// conversion clock tick generator: one pulse every 4, 8, 16 or 32 cycles
// assumes cks is stable while the module runs; run low holds it in reset
`timescale 1ns/1ns
`include "adc_ctrl_consts.vh"
module clk_div_tick (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// control
	input wire run,
	input wire [1:0] cks,
	// output
	output reg tick
);
	reg [4:0] cnt_r;
	reg [4:0] lim;

	// terminal count from the divider code
	always @* begin
		case (cks)
			`CKS_DIV32: lim = 5'h1F;
			`CKS_DIV16: lim = 5'h0F;
			`CKS_DIV8: lim = 5'h07;
			default: lim = 5'h03;
		endcase
	end

	// free count while running, restart from zero when stopped
	always @(posedge aclk) begin
		if (!aresetn || !run) begin
			cnt_r <= 5'h00;
			tick <= 1'b0;
		end else begin
			tick <= (cnt_r == lim);
			cnt_r <= (cnt_r == lim) ? 5'h00 : cnt_r + 5'h01;
		end
	end
endmodule

/* File: conv_sequencer.v */
// per-module conversion sequencer: walks channels, reports ends
// assumes start/mode/channel fields stay stable while busy
`timescale 1ns/1ns
`include "adc_ctrl_consts.vh"
module conv_sequencer (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// control
	input wire start,
	input wire scan,
	input wire continuous,
	input wire [1:0] ch_sel,
	input wire tick,
	// status
	output reg [1:0] chan,
	output reg chan_done,
	output reg pass_done,
	output reg busy
);
	reg [3:0] tcnt_r;

	// each channel takes a fixed number of conversion clock ticks
	always @(posedge aclk) begin
		if (!aresetn || !start) begin
			tcnt_r <= 4'h0;
			chan <= 2'h0;
			chan_done <= 1'b0;
			pass_done <= 1'b0;
			busy <= 1'b0;
		end else begin
			busy <= 1'b1;
			chan_done <= 1'b0;
			pass_done <= 1'b0;
			if (!busy) begin
				chan <= scan ? 2'h0 : ch_sel;
			end else if (tick) begin
				if (tcnt_r == `CONV_TICKS - 4'h1) begin
					tcnt_r <= 4'h0;
					chan_done <= 1'b1;
					if (!scan || chan == ch_sel) begin
						pass_done <= 1'b1;
						if (scan && continuous)
							chan <= 2'h0;
					end else begin
						chan <= chan + 2'h1;
					end
				end else begin
					tcnt_r <= tcnt_r + 4'h1;
				end
			end
		end
	end
endmodule

/* File: adc_ctrl_monitor.sv */
// checker for the converter control block, ports only
// assumes one clock domain and the bind at the foot
`timescale 1ns/1ns
`include "adc_ctrl_consts.vh"
module adc_ctrl_monitor (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// bus answers
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	// converter status
	input wire [7:0] analog_input_sel,
	input wire [1:0] busy
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire [3:0] s0 = analog_input_sel[3:0];
	// a fresh channel of module zero, then its minimum dwell
	sequence new_chan;
		$changed(s0) && s0 != 4'h0;
	endsequence
	// a stop may drop the channel early, so zero is allowed
	sequence dwell;
		(s0 == $past(s0) || s0 == 4'h0) [*8];
	endsequence
	a_sel_onehot: assert property (
		$onehot0(s0) && $onehot0(analog_input_sel[7:4]))
		else $error("channel select not one-hot");
	a_scan_ascend: assert property (
		new_chan and $past(s0) != 4'h0 |-> s0 == $past(s0) << 1 || s0 == 4'h1)
		else $error("scan order broken");
	a_chan_dwell: assert property (new_chan |=> dwell)
		else $error("channel dwell too short");
	a_sel_busy: assert property (
		|analog_input_sel[7:4] |-> busy[1] || $past(busy[1]))
		else $error("channel selected while idle");
	a_bvalid_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rvalid_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 0)
		else $error("upper read bits not zero");
	a_bresp_code: assert property (s_axi_bvalid |->
		s_axi_bresp == `RESP_OKAY || s_axi_bresp == `RESP_SLVERR)
		else $error("bad write response code");
endmodule
bind adc_channel_trigger_clock_ctrl adc_ctrl_monitor adc_ctrl_monitor_i (
	.aclk(aclk), .aresetn(aresetn), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .analog_input_sel(analog_input_sel),
	.busy(busy));

/* File: trig_src.sv */
// trigger source model: pulses the trigger lines on command
// assumes go is raised for one cycle per pulse
`timescale 1ns/1ns
module trig_src (
	// clock
	input wire aclk,
	// command: bit 2 pin, bits 1:0 timer lines
	input wire [2:0] go,
	// trigger lines
	output reg external_trigger_pin,
	output reg [1:0] timer_unit_trigger
);
	reg [1:0] cnt_r = 2'h0;
	reg [2:0] lvl_r = 3'h0;
	// four cycles high, longer than the two the synchroniser needs
	always @(posedge aclk) begin
		if (|go) begin
			lvl_r <= go;
			cnt_r <= 2'h3;
		end else if (cnt_r != 2'h0)
			cnt_r <= cnt_r - 2'h1;
		else
			lvl_r <= 3'h0;
	end
	// lines low between pulses
	always @* {external_trigger_pin, timer_unit_trigger} = lvl_r;
endmodule

/* File: adc_channel_trigger_clock_ctrl_tb.sv */
// bench for the converter control block over its register bus
// assumes the trigger model and the bound checker beside it
`timescale 1ns/1ns
`include "adc_ctrl_consts.vh"
module adc_channel_trigger_clock_ctrl_tb;
	reg aclk = 1'b0;
	reg aresetn = 1'b0;
	reg [4:0] awaddr = 5'h00;
	reg [4:0] araddr = 5'h00;
	reg [31:0] wdata = 32'h0;
	reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	reg arvalid = 1'b0, rready = 1'b0;
	reg [2:0] go = 3'h0;
	wire awready, wready, bvalid, arready, rvalid, irq, ext;
	wire [1:0] bresp, rresp, busy, tmr;
	wire [31:0] rdata;
	wire [7:0] sel;
	integer n_fail = 0;
	integer num_checks = 0;
	integer i;
	reg [7:0] seen;
	reg [20:0] rows [0:5];
	adc_channel_trigger_clock_ctrl adc_channel_trigger_clock_ctrl_i (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .external_trigger_pin(ext),
		.timer_unit_trigger(tmr), .analog_input_sel(sel), .busy(busy),
		.irq(irq));
	trig_src trig_src_i (.aclk(aclk), .go(go),
		.external_trigger_pin(ext), .timer_unit_trigger(tmr));
	// free-running clock
	initial forever #10 aclk = ~aclk;
	task wrap_up;
		begin
			$display("checks %0d mismatches %0d", num_checks, n_fail);
			if (n_fail == 0 && num_checks > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
		begin
			num_checks = num_checks + 1;
			if (g !== e) begin
				n_fail = n_fail + 1;
				$display("wrong value %0s exp %h got %h", nm, e, g);
			end
		end
	endtask
	task tmo;
		begin
			chk("wait", 32'h1, 32'h0);
			wrap_up;
		end
	endtask
	// write: both channels offered together, each dropped when taken
	task wr(input [4:0] a, input [7:0] d, input [1:0] er);
		integer k;
		begin
			@(posedge aclk);
			awaddr <= a;
			wdata <= {24'h0, d};
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			for (k = 0; k < 50 && bvalid !== 1'b1; k = k + 1) begin
				@(posedge aclk);
				if (awready === 1'b1) awvalid <= 1'b0;
				if (wready === 1'b1) wvalid <= 1'b0;
			end
			if (k == 50) tmo;
			chk("bresp", {30'h0, er}, {30'h0, bresp});
			bready <= 1'b0;
		end
	endtask
	// read and compare one register
	task rc(input [4:0] a, input [7:0] e);
		integer k;
		begin
			@(posedge aclk);
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			for (k = 0; k < 50 && rvalid !== 1'b1; k = k + 1) begin
				@(posedge aclk);
				if (arready === 1'b1) arvalid <= 1'b0;
			end
			if (k == 50) tmo;
			chk("rdata", {24'h0, e}, rdata);
			chk("rresp", {30'h0, `RESP_OKAY}, {30'h0, rresp});
			rready <= 1'b0;
		end
	endtask
	// wait on a module's busy, gathering every channel it selects
	task wb(input integer m, input v);
		integer k;
		begin
			for (k = 0; k < 2000 && busy[m] !== v; k = k + 1) begin
				@(posedge aclk);
				seen = seen | sel;
			end
			if (k == 2000) tmo;
		end
	endtask
	task fire(input [2:0] v);
		begin
			@(posedge aclk);
			go <= v;
			@(posedge aclk);
			go <= 3'h0;
		end
	endtask
	task conv(input integer m, input [4:0] a, input [7:0] c, input [7:0] t);
		begin
			wr(a, c, `RESP_OKAY);
			wr(a + 5'h04, t, `RESP_OKAY);
			seen = 8'h00;
			wb(m, 1'b1);
			wb(m, 1'b0);
		end
	endtask
	initial begin
		rows[0] = {5'h00, 8'h93, 8'h1B};
		rows[1] = {5'h00, 8'h02, 8'h0A};
		rows[2] = {5'h04, 8'hE0, 8'hE7};
		rows[3] = {5'h0C, 8'h60, 8'h67};
		rows[4] = {5'h04, 8'h40, 8'h47};
		rows[5] = {5'h14, 8'h03, 8'h03};
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		for (i = 0; i < 6; i = i + 1) begin
			wr(rows[i][20:16], rows[i][15:8], `RESP_OKAY);
			rc(rows[i][20:16], rows[i][7:0]);
		end
		// second reset while both modules idle must restore every field of the four module registers
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rc(5'h00, 8'h08);
		rc(5'h04, 8'h07);
		rc(5'h08, 8'h08);
		rc(5'h0C, 8'h07);
		wr(5'h18, 8'hFF, `RESP_SLVERR);
		fire(3'h1);
		repeat (20) @(posedge aclk);
		chk("busy", 32'h0, {30'h0, busy});
		conv(0, 5'h00, 8'h02, 8'h70);
		chk("seen", 32'h04, {24'h0, seen});
		rc(5'h00, 8'h8A);
		rc(5'h04, 8'h67);
		wr(5'h00, 8'h8A, `RESP_OKAY);
		rc(5'h00, 8'h8A);
		wr(5'h00, 8'h0A, `RESP_OKAY);
		rc(5'h00, 8'h0A);
		chk("irq", 32'h0, {31'h0, irq});
		conv(1, 5'h08, 8'h13, 8'h70);
		chk("seen", 32'hF0, {24'h0, seen});
		rc(5'h08, 8'h9B);
		rc(5'h0C, 8'h67);
		rc(5'h10, 8'h03);
		wr(5'h14, 8'h03, `RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk("irq", 32'h1, {31'h0, irq});
		wr(5'h10, 8'h03, `RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk("irq", 32'h0, {31'h0, irq});
		wr(5'h00, 8'h00, `RESP_OKAY);
		wr(5'h04, 8'hE0, `RESP_OKAY);
		fire(3'h4);
		wb(0, 1'b1);
		rc(5'h04, 8'hF7);
		chk("busy1", 32'h0, {31'h0, busy[1]});
		wb(0, 1'b0);
		wr(5'h00, 8'h11, `RESP_OKAY);
		wr(5'h04, 8'h78, `RESP_OKAY);
		wb(0, 1'b1);
		repeat (200) @(posedge aclk);
		chk("busy0", 32'h1, {31'h0, busy[0]});
		wr(5'h04, 8'h60, `RESP_OKAY);
		wb(0, 1'b0);
		wrap_up;
	end
endmodule
